// [sbpr_host_model.sv]
// AXI4-Lite master standing in for the host that reads the parameter ROM.
// Assumes the bench calls its tasks right after a rising edge of aclk.
`timescale 1ns/1ps
module sbpr_host_model (
  input wire logic aclk,
  output logic [sbpr_pkg::SBPR_AW-1:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  output logic [sbpr_pkg::SBPR_AW-1:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  import sbpr_pkg::*;

  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  // Handshakes are judged at the falling edge, where inputs are settled,
  // and acted on at the next rising edge so no race with the slave.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    output logic [1:0] r);
    logic pa;
    logic pw;
    logic ha;
    logic hw;
    logic hb;
    int n;
    n = $urandom_range(2, 0);
    pa = 1'b1;
    pw = 1'b1;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (pa || pw) begin
      @(negedge aclk);
      ha = pa && (awready === 1'b1);
      hw = pw && (wready === 1'b1);
      @(posedge aclk);
      if (ha) begin
        awvalid <= 1'b0;
        pa = 1'b0;
      end
      if (hw) begin
        wvalid <= 1'b0;
        pw = 1'b0;
      end
    end
    // A late ready makes the slave show that it holds its answer
    repeat (n) @(posedge aclk);
    bready <= 1'b1;
    do begin
      @(negedge aclk);
      hb = (bvalid === 1'b1);
      r = bresp;
      @(posedge aclk);
    end while (!hb);
    bready <= 1'b0;
  endtask : wr

  // Read one register at byte address a and return its data and response
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic h;
    int n;
    n = $urandom_range(2, 0);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(negedge aclk);
      h = (arready === 1'b1);
      @(posedge aclk);
    end while (!h);
    arvalid <= 1'b0;
    // Ready raised late at random, so a waiting answer is exercised
    repeat (n) @(posedge aclk);
    rready <= 1'b1;
    do begin
      @(negedge aclk);
      h = (rvalid === 1'b1);
      d = rdata;
      r = rresp;
      @(posedge aclk);
    end while (!h);
    rready <= 1'b0;
  endtask : rd

  // Idle bus at time zero
  initial begin
    awaddr = 8'h00;
    awvalid = 1'b0;
    wdata = 32'h0;
    wstrb = 4'h0;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = 8'h00;
    arvalid = 1'b0;
    rready = 1'b0;
  end
endmodule : sbpr_host_model

// [sbpr_pkg.sv]
// Constants, field layouts and carriers for the discoverable parameter ROM.
// Assumes a single 40 MHz clock domain and an AXI4-Lite master with 32-bit data.
package sbpr_pkg;

  // ----------------------------------------------------------------
  // Bus geometry and response codes
  // ----------------------------------------------------------------
  localparam int SBPR_AW = 8;
  localparam logic [1:0] SBPR_RESP_OKAY = 2'h0;
  localparam logic [1:0] SBPR_RESP_SLVERR = 2'h2;
  localparam logic [1:0] SBPR_RESP_DECERR = 2'h3;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [SBPR_AW-1:0] SBPR_OFF_HDR1_DW1 = 8'h00;
  localparam logic [SBPR_AW-1:0] SBPR_OFF_HDR1_DW2 = 8'h04;
  localparam logic [SBPR_AW-1:0] SBPR_OFF_BASIC_DW1 = 8'h08;
  localparam logic [SBPR_AW-1:0] SBPR_OFF_BASIC_DW2 = 8'h0C;
  localparam logic [SBPR_AW-1:0] SBPR_OFF_BASIC_DW3 = 8'h10;
  localparam logic [SBPR_AW-1:0] SBPR_OFF_WIN_ADDR = 8'h14;
  localparam logic [SBPR_AW-1:0] SBPR_OFF_WIN_DATA = 8'h18;
  localparam logic [23:0] SBPR_WIN_ADDR_RST = 24'h000000;
  localparam logic [7:0] SBPR_BYTE_UNMAPPED = 8'hFF;

  // ----------------------------------------------------------------
  // Second parameter header
  // ----------------------------------------------------------------
  localparam logic [23:0] SBPR_HDR1_BASE = 24'h000010;
  localparam logic [7:0] SBPR_HDR1_ID_LSB = 8'h84;
  localparam logic [7:0] SBPR_HDR1_MINOR = 8'h00;
  localparam logic [7:0] SBPR_HDR1_MAJOR = 8'h01;
  localparam logic [7:0] SBPR_HDR1_LEN = 8'h02;
  localparam logic [23:0] SBPR_TABLE_BASE = 24'h000340;
  localparam logic [7:0] SBPR_HDR1_ID_MSB = 8'hFF;
  localparam logic [31:0] SBPR_HDR1_DW1 =
    {SBPR_HDR1_LEN, SBPR_HDR1_MAJOR, SBPR_HDR1_MINOR, SBPR_HDR1_ID_LSB};
  localparam logic [31:0] SBPR_HDR1_DW2 = {SBPR_HDR1_ID_MSB, SBPR_TABLE_BASE};

  // ----------------------------------------------------------------
  // Basic parameter table fields
  // ----------------------------------------------------------------
  localparam logic [2:0] SBPR_B0_UNUSED = 3'h7;
  localparam logic [1:0] SBPR_B0_VOL_WR = 2'h0;
  localparam logic [0:0] SBPR_B0_BUF_GT64 = 1'h1;
  localparam logic [1:0] SBPR_B0_ERASE_4K = 2'h1;
  localparam logic [7:0] SBPR_B0 =
    {SBPR_B0_UNUSED, SBPR_B0_VOL_WR, SBPR_B0_BUF_GT64, SBPR_B0_ERASE_4K};
  localparam logic [7:0] SBPR_B1_ERASE_4K_CMD = 8'h20;
  localparam logic [0:0] SBPR_B2_UNUSED = 1'h1;
  localparam logic [0:0] SBPR_B2_QUAD_OUTPUT_READ = 1'h1;
  localparam logic [0:0] SBPR_B2_QUAD_ADDR_DATA_READ = 1'h1;
  localparam logic [0:0] SBPR_B2_DUAL_ADDR_DATA_READ = 1'h1;
  localparam logic [0:0] SBPR_B2_DDR = 1'h1;
  localparam logic [1:0] SBPR_B2_ADDR_BYTES = 2'h1;
  localparam logic [0:0] SBPR_B2_FAST_SINGLE_LINE_IO = 1'h1;
  localparam logic [7:0] SBPR_B2 =
    {SBPR_B2_UNUSED, SBPR_B2_QUAD_OUTPUT_READ, SBPR_B2_QUAD_ADDR_DATA_READ,
     SBPR_B2_DUAL_ADDR_DATA_READ, SBPR_B2_DDR, SBPR_B2_ADDR_BYTES,
     SBPR_B2_FAST_SINGLE_LINE_IO};
  localparam logic [7:0] SBPR_B3 = 8'hFF;
  localparam logic [31:0] SBPR_DENSITY = 32'h03FFFFFF;
  localparam logic [2:0] SBPR_QIO_MODE_CYC = 3'h2;
  localparam logic [4:0] SBPR_QIO_DUMMY_CYC = 5'h08;
  localparam logic [7:0] SBPR_B8 = {SBPR_QIO_MODE_CYC, SBPR_QIO_DUMMY_CYC};
  localparam logic [7:0] SBPR_B9_QIO_CMD = 8'hEB;
  localparam logic [31:0] SBPR_BASIC_DW1 = {SBPR_B3, SBPR_B2, SBPR_B1_ERASE_4K_CMD, SBPR_B0};
  localparam logic [31:0] SBPR_BASIC_DW3 = {16'h0000, SBPR_B9_QIO_CMD, SBPR_B8};
  localparam int SBPR_HDR1_BYTES = 8;
  localparam int SBPR_TABLE_BYTES = 10;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] data;
    logic [1:0] resp;
  } sbpr_rsp_s;

  // Byte at an address of the discoverable parameter space
  function automatic logic [7:0] sbpr_byte_at(input logic [23:0] a);
    logic [23:0] off_h;
    logic [23:0] off_t;
    logic [63:0] hdr;
    logic [79:0] tbl;
    off_h = a - SBPR_HDR1_BASE;
    off_t = a - SBPR_TABLE_BASE;
    hdr = {SBPR_HDR1_DW2, SBPR_HDR1_DW1};
    tbl = {SBPR_BASIC_DW3[15:0], SBPR_DENSITY, SBPR_BASIC_DW1};
    if (a >= SBPR_HDR1_BASE && off_h < 24'(SBPR_HDR1_BYTES)) begin
      sbpr_byte_at = hdr[{off_h[2:0], 3'h0} +: 8];
    end else if (a >= SBPR_TABLE_BASE && off_t < 24'(SBPR_TABLE_BYTES)) begin
      sbpr_byte_at = tbl[{off_t[3:0], 3'h0} +: 8];
    end else begin
      sbpr_byte_at = SBPR_BYTE_UNMAPPED;
    end
  endfunction : sbpr_byte_at

endpackage : sbpr_pkg

// [sbpr_rom.sv]
// AXI4-Lite register view of the discoverable parameter ROM tail.
// Assumes one master with at most one read and one write under way.
`timescale 1ns/1ps

// How it works
// [RL1] Header two table length reads 02h
// [RL2] Header two pointer bytes 40h 03h 00h
// [RL3] Header two identifier MSB reads FFh
// [RL4] Table byte 0 reads E5h
// [RL5] Table byte 1 holds erase command 20h
// [RL6] Table byte 2 reads FBh read support
// [RL7] Address byte field encodes three or four
// [RL8] Table byte 3 reads FFh unused
// [RL9] Density bytes report 03FFFFFFh
// [RL10] Table byte 8 reads 48h cycles
// [RL11] Table byte 9 holds command EBh
// [RL12] Header two identifier LSB reads 84h
// [RL13] Bytes read at base plus offset, never altered
module sbpr_rom (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [sbpr_pkg::SBPR_AW-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [sbpr_pkg::SBPR_AW-1:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);
  import sbpr_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic aw_held;
  logic w_held;
  logic [SBPR_AW-1:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic [23:0] win_addr;
  logic [SBPR_AW-1:0] rd_sel;
  sbpr_rsp_s rd_rsp;
  sbpr_rsp_s next_rd_rsp;
  logic [SBPR_AW-1:0] ar_word;
  logic [SBPR_AW-1:0] aw_word;
  logic wr_fire;

  // Protection bits carry no meaning for a constant table
  logic prot_unused;
  assign prot_unused = ^{awprot, arprot};

  assign ar_word = {araddr[SBPR_AW-1:2], 2'h0};
  assign aw_word = {aw_addr_q[SBPR_AW-1:2], 2'h0};
  assign wr_fire = aw_held && w_held && !bvalid;

  // ----------------------------------------------------------------
  // Read decode
  // ----------------------------------------------------------------
  // Constant words; the window register returns the byte it points at
  always_comb begin
    next_rd_rsp.resp = SBPR_RESP_OKAY;
    next_rd_rsp.data = 32'h00000000;
    case (ar_word)
      SBPR_OFF_HDR1_DW1: next_rd_rsp.data = SBPR_HDR1_DW1; // RL1 RL12
      SBPR_OFF_HDR1_DW2: next_rd_rsp.data = SBPR_HDR1_DW2; // RL2 RL3
      SBPR_OFF_BASIC_DW1: next_rd_rsp.data = SBPR_BASIC_DW1; // RL4 RL5 RL6 RL7 RL8
      SBPR_OFF_BASIC_DW2: next_rd_rsp.data = SBPR_DENSITY; // RL9
      SBPR_OFF_BASIC_DW3: next_rd_rsp.data = SBPR_BASIC_DW3; // RL10 RL11
      SBPR_OFF_WIN_ADDR: next_rd_rsp.data = {8'h00, win_addr};
      SBPR_OFF_WIN_DATA: next_rd_rsp.data = {24'h000000, sbpr_byte_at(win_addr)}; // RL13
      default: next_rd_rsp.resp = SBPR_RESP_DECERR;
    endcase
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  // Ready drops while an answer waits, so only one read is in flight
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
    end else if (!rvalid || rready) begin
      arready <= 1'b1;
    end
  end

  // Answer is registered one edge after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rd_rsp <= '0;
      rd_sel <= '0;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rd_rsp <= next_rd_rsp;
      rd_sel <= ar_word;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

  assign rdata = rd_rsp.data;
  assign rresp = rd_rsp.resp;

  // ----------------------------------------------------------------
  // Write channels
  // ----------------------------------------------------------------
  // Address and data are caught in either order and held until both exist
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      aw_held <= 1'b0;
      aw_addr_q <= '0;
    end else if (awvalid && awready) begin
      awready <= 1'b0;
      aw_held <= 1'b1;
      aw_addr_q <= awaddr;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end else if (!aw_held && (!bvalid || bready)) begin
      awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready <= 1'b0;
      w_held <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= '0;
    end else if (wvalid && wready) begin
      wready <= 1'b0;
      w_held <= 1'b1;
      w_data_q <= wdata;
      w_strb_q <= wstrb;
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end else if (!w_held && (!bvalid || bready)) begin
      wready <= 1'b1;
    end
  end

  // Response follows both halves; table words refuse writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= SBPR_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid <= 1'b1;
      case (aw_word)
        SBPR_OFF_WIN_ADDR: bresp <= SBPR_RESP_OKAY;
        SBPR_OFF_HDR1_DW1, SBPR_OFF_HDR1_DW2, SBPR_OFF_BASIC_DW1,
        SBPR_OFF_BASIC_DW2, SBPR_OFF_BASIC_DW3,
        SBPR_OFF_WIN_DATA: bresp <= SBPR_RESP_SLVERR; // RL13
        default: bresp <= SBPR_RESP_DECERR;
      endcase
    end else if (bvalid && bready) begin
      bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Window pointer into the parameter space
  // ----------------------------------------------------------------
  // Byte lanes honoured; lane 3 has no storage and is dropped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      win_addr <= SBPR_WIN_ADDR_RST;
    end else if (wr_fire && aw_word == SBPR_OFF_WIN_ADDR) begin
      for (int i = 0; i < 3; i++) begin
        if (w_strb_q[i]) begin
          win_addr[8*i +: 8] <= w_data_q[8*i +: 8];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_ar_take;
    arvalid && arready;
  endsequence

  sequence s_rd_of(logic [SBPR_AW-1:0] off);
    $rose(rvalid) && rd_sel == off && rresp == SBPR_RESP_OKAY;
  endsequence

  property p_hdr_len;
    s_rd_of(SBPR_OFF_HDR1_DW1) |-> rdata[31:24] == 8'h02;
  endproperty
  a_hdr_len: assert property (p_hdr_len) // RL1
    else $error("header length byte wrong");

  property p_hdr_ptr;
    s_rd_of(SBPR_OFF_HDR1_DW2) |-> rdata[23:0] == 24'h000340;
  endproperty
  a_hdr_ptr: assert property (p_hdr_ptr) // RL2
    else $error("header pointer wrong");

  property p_hdr_id_msb;
    s_rd_of(SBPR_OFF_HDR1_DW2) |-> rdata[31:24] == 8'hFF;
  endproperty
  a_hdr_id_msb: assert property (p_hdr_id_msb) // RL3
    else $error("header id msb wrong");

  property p_tbl_b0_b1;
    s_rd_of(SBPR_OFF_BASIC_DW1) |-> rdata[7:0] == 8'hE5 && rdata[15:8] == 8'h20;
  endproperty
  a_tbl_b0_b1: assert property (p_tbl_b0_b1) // RL4 RL5
    else $error("table bytes 0 and 1 wrong");

  property p_tbl_b2_b3;
    s_rd_of(SBPR_OFF_BASIC_DW1) |->
      rdata[23:16] == 8'hFB && rdata[18:17] == 2'h1 && rdata[31:24] == 8'hFF;
  endproperty
  a_tbl_b2_b3: assert property (p_tbl_b2_b3) // RL6 RL7 RL8
    else $error("table bytes 2 and 3 wrong");

  property p_density;
    s_rd_of(SBPR_OFF_BASIC_DW2) |-> rdata == 32'h03FFFFFF;
  endproperty
  a_density: assert property (p_density) // RL9
    else $error("density word wrong");

  property p_qio;
    s_rd_of(SBPR_OFF_BASIC_DW3) |-> rdata[7:0] == 8'h48 && rdata[15:8] == 8'hEB;
  endproperty
  a_qio: assert property (p_qio) // RL10 RL11
    else $error("quad read bytes wrong");

  property p_hdr_id_lsb;
    s_rd_of(SBPR_OFF_HDR1_DW1) |-> rdata[7:0] == 8'h84;
  endproperty
  a_hdr_id_lsb: assert property (p_hdr_id_lsb) // RL12
    else $error("header id lsb wrong");

  property p_win_byte;
    s_rd_of(SBPR_OFF_WIN_DATA) |-> rdata[7:0] == sbpr_byte_at($past(win_addr));
  endproperty
  a_win_byte: assert property (p_win_byte) // RL13
    else $error("window byte does not match table");

  property p_rom_write_refused;
    $rose(bvalid) && aw_word == SBPR_OFF_BASIC_DW1 |->
      bresp == SBPR_RESP_SLVERR && $stable(win_addr);
  endproperty
  a_rom_write_refused: assert property (p_rom_write_refused) // RL13
    else $error("table write was not refused");

  // An answer not yet taken keeps its data and code
  property p_read_answer;
    rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp);
  endproperty
  a_read_answer: assert property (p_read_answer)
    else $error("read answer changed before it was taken");

  property p_read_latency;
    s_ar_take |=> rvalid && !arready;
  endproperty
  a_read_latency: assert property (p_read_latency)
    else $error("read answer not one cycle after address");

  property p_write_latency;
    aw_held && w_held && !bvalid |=> bvalid && !aw_held && !w_held;
  endproperty
  a_write_latency: assert property (p_write_latency)
    else $error("write answer not one cycle after both halves");

  // A write answer holds until the master takes it
  property p_write_answer;
    bvalid && !bready |=> bvalid && $stable(bresp);
  endproperty
  a_write_answer: assert property (p_write_answer)
    else $error("write answer changed before it was taken");

  // Only one read in flight; a pending answer closes the address channel
  property p_read_refused;
    rvalid |-> !arready;
  endproperty
  a_read_refused: assert property (p_read_refused)
    else $error("read address open while an answer waits");

  // A held write address blocks a second one
  property p_aw_refused;
    aw_held |-> !awready;
  endproperty
  a_aw_refused: assert property (p_aw_refused)
    else $error("write address open while one is held");

  // A held write data beat blocks a second one
  property p_w_refused;
    w_held |-> !wready;
  endproperty
  a_w_refused: assert property (p_w_refused)
    else $error("write data open while one is held");

  // Reset leaves the pointer at zero and every handshake closed
  property p_reset_state;
    $rose(aresetn) |->
      win_addr == 24'h000000 && !rvalid && !bvalid && !arready && !awready && !wready;
  endproperty
  a_reset_state: assert property (p_reset_state)
    else $error("state after reset wrong");

  // Any write outside the pointer is refused and leaves the pointer alone
  property p_write_refused;
    $rose(bvalid) && aw_word != SBPR_OFF_WIN_ADDR |->
      bresp != SBPR_RESP_OKAY && $stable(win_addr);
  endproperty
  a_write_refused: assert property (p_write_refused) // RL13
    else $error("write outside the pointer was accepted");

  // Unmapped reads give zero data with the decode error
  property p_unmapped_read;
    $rose(rvalid) && rresp == SBPR_RESP_DECERR |-> rdata == 32'h00000000;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read)
    else $error("unmapped read data not zero");

  // An enabled lane 0 lands in pointer byte 0
  property p_win_lane_set;
    wr_fire && aw_word == SBPR_OFF_WIN_ADDR && w_strb_q[0] |=>
      win_addr[7:0] == w_data_q[7:0];
  endproperty
  a_win_lane_set: assert property (p_win_lane_set)
    else $error("enabled pointer lane not written");

  // A disabled lane 1 keeps its old pointer byte
  property p_win_lane_keep;
    wr_fire && aw_word == SBPR_OFF_WIN_ADDR && !w_strb_q[1] |=>
      $stable(win_addr[15:8]);
  endproperty
  a_win_lane_keep: assert property (p_win_lane_keep)
    else $error("disabled pointer lane changed");

endmodule : sbpr_rom

// [sbpr_rom_tb_top.sv]
// Self-checking bench for the parameter ROM register view.
// Assumes sbpr_pkg and the host model are compiled first.
`timescale 1ns/1ps
module sbpr_rom_tb_top;
  import sbpr_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  int error_cnt = 0;
  int comparisons = 0;
  int cyc = 0;

  always #12.5 aclk = ~aclk;

  sbpr_rom dut_u (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready));

  sbpr_host_model host_u (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

  // ----------------------------------------------------------------
  // Expectations and checks
  // ----------------------------------------------------------------
  // Documented byte of parameter space; anything else reads FFh
  function automatic logic [7:0] exp_byte(input logic [23:0] a);
    case (a)
      24'h10: return 8'h84;
      24'h11: return SBPR_HDR1_MINOR;
      24'h12: return SBPR_HDR1_MAJOR;
      24'h13: return 8'h02;
      24'h14: return 8'h40;
      24'h15: return 8'h03;
      24'h16: return 8'h00;
      24'h340: return 8'hE5;
      24'h341: return 8'h20;
      24'h342: return 8'hFB;
      24'h347: return 8'h03;
      24'h348: return 8'h48;
      24'h349: return 8'hEB;
      default: return 8'hFF;
    endcase
  endfunction : exp_byte

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // Every constant word, least significant byte at the lowest address
  task automatic chk_words();
    logic [31:0] d;
    logic [31:0] e;
    logic [1:0] r;
    logic [23:0] b;
    for (int i = 0; i < 5; i++) begin
      b = (i < 2) ? 24'h10 + 24'(4 * i) : 24'h340 + 24'(4 * (i - 2));
      e = {exp_byte(b + 3), exp_byte(b + 2), exp_byte(b + 1), exp_byte(b)};
      if (i == 4) e[31:16] = 16'h0;
      host_u.rd(8'(4 * i), d, r);
      chk("word", e, d);
      chk("word resp", 32'(SBPR_RESP_OKAY), 32'(r));
      if (i == 2) chk("addr bytes", 32'h1, 32'(d[18:17]));
    end
  endtask : chk_words

  // Point the window at a byte and read it back
  task automatic chk_win(input logic [23:0] a);
    logic [31:0] d;
    logic [1:0] r;
    host_u.wr(SBPR_OFF_WIN_ADDR, {8'($urandom), a}, 4'hF, r);
    chk("pointer write", 32'(SBPR_RESP_OKAY), 32'(r));
    host_u.rd(SBPR_OFF_WIN_ADDR, d, r);
    chk("pointer", {8'h0, a}, d);
    host_u.rd(SBPR_OFF_WIN_DATA, d, r);
    chk("window byte", {24'h0, exp_byte(a)}, d);
  endtask : chk_win

  task automatic close_out();
    if (error_cnt == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : close_out

  // Hang guard, well above the few hundred cycles the run needs
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      error_cnt++;
      close_out();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    logic [7:0] offs [6];
    d = $urandom(32'h2C3F7819);
    offs = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h18};
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    chk_words();
    for (int a = 'h10; a < 'h18; a++) chk_win(24'(a));
    for (int a = 'h33E; a < 'h34B; a++) chk_win(24'(a));
    repeat (12) chk_win(24'($urandom));
    // Partial strobe moves only lane 0 of the pointer
    chk_win(24'h000340);
    host_u.wr(SBPR_OFF_WIN_ADDR, 32'hAABBCC55, 4'h1, r);
    chk("strobe write", 32'(SBPR_RESP_OKAY), 32'(r));
    host_u.rd(SBPR_OFF_WIN_ADDR, d, r);
    chk("strobe pointer", 32'h00000355, d);
    // Constant words and the window data register refuse writes; constant words keep their values
    foreach (offs[i]) begin
      host_u.wr(offs[i], $urandom, 4'hF, r);
      chk("const write", 32'(SBPR_RESP_SLVERR), 32'(r));
    end
    chk_words();
    host_u.wr(8'h40, $urandom, 4'hF, r);
    chk("unmapped write", 32'(SBPR_RESP_DECERR), 32'(r));
    host_u.rd(8'h40, d, r);
    chk("unmapped read", 32'h00000000, d);
    chk("unmapped resp", 32'(SBPR_RESP_DECERR), 32'(r));
    close_out();
  end
endmodule : sbpr_rom_tb_top
